/* File: inc/pes_pkg.sv */
// constants and types for the pattern exposure sequencer
package pes_pkg;

	// ********************************
	// clock and timing
	// ********************************
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int TW = 24;
	localparam int FTRIG_MIN_NS = 20_000;
	localparam int FTRIG_CYC = (FTRIG_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PAT1_MAX_HZ = 2500;
	localparam int PAT1_MIN_CYC = (CLK_HZ + PAT1_MAX_HZ - 1) / PAT1_MAX_HZ;
	localparam int EXT8_MAX_MHZ = 120_000;
	localparam int EXT1_MAX_MHZ = 104_200;
	localparam longint EXT8_MIN_FRAME_CYC = (longint'(CLK_HZ) * 1000 + EXT8_MAX_MHZ - 1) / EXT8_MAX_MHZ;
	localparam longint EXT1_MIN_FRAME_CYC = (longint'(CLK_HZ) * 1000 + EXT1_MAX_MHZ - 1) / EXT1_MAX_MHZ;

	// ********************************
	// sizes
	// ********************************
	localparam int VW = 24;
	localparam int PW = 8;
	localparam int EXT8_MAX_PAT = 3;
	localparam int EXT1_MAX_PAT = 24;
	localparam int MEM_AW = 6;
	localparam int MEM_DEPTH = 64;
	localparam int ILL_W = 3;
	localparam int APB_AW = 8;

	// ********************************
	// register offsets
	// ********************************
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] REG_PRE_DARK = 8'h04;
	localparam logic [APB_AW-1:0] REG_EXPOSURE = 8'h08;
	localparam logic [APB_AW-1:0] REG_POST_DARK = 8'h0C;
	localparam logic [APB_AW-1:0] REG_FTRIG_DLY = 8'h10;
	localparam logic [APB_AW-1:0] REG_PTRIG_DLY = 8'h14;
	localparam logic [APB_AW-1:0] REG_ILLUM = 8'h18;
	localparam logic [APB_AW-1:0] REG_SET_PERIOD = 8'h1C;
	localparam logic [APB_AW-1:0] REG_MEM_ADDR = 8'h20;
	localparam logic [APB_AW-1:0] REG_MEM_DATA = 8'h24;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h28;

	// ********************************
	// field positions and reset values
	// ********************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TRIGIN_BIT = 2;
	localparam int CTRL_RUN_BIT = 3;
	localparam int CTRL_PPF_LSB = 4;
	localparam int CTRL_CNT_LSB = 8;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_RATE_BIT = 1;
	localparam int STAT_ST_LSB = 4;
	localparam int STAT_IDX_LSB = 8;
	localparam logic [TW-1:0] TIME_RST = 24'h00_0000;
	localparam logic [8:0] ILLUM_RST = 9'h000;

	typedef enum logic [1:0] {MODE_OFF, MODE_EXT8, MODE_EXT1, MODE_INT} pes_mode_type;
	typedef enum logic [2:0] {S_IDLE, S_PRE, S_EXP, S_POST, S_FILL, S_WAIT} pes_state_type;

endpackage : pes_pkg

/* File: inc/pes_mem_if.sv */
// pattern memory write and read port bundle
`timescale 1ns/10ps
`default_nettype none
interface pes_mem_if;
	import pes_pkg::*;
	logic we;
	logic [MEM_AW-1:0] waddr;
	logic [PW-1:0] wdata;
	logic [MEM_AW-1:0] raddr;
	logic [PW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pes_mem_if
`default_nettype wire

/* File: core/pes_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pes_sync
	import pes_pkg::*;
#(
	parameter int W = 1
)(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pes_sync_type;

	pes_sync_type sync_reg;
	pes_sync_type sync_next;

	// ********************************
	// bit takes new value when stages two and three agree
	// ********************************
	always_comb
	begin
		sync_next = sync_reg;
		sync_next.s1 = d_i;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.q = (sync_reg.s2 & sync_reg.s3) | (sync_reg.q & (sync_reg.s2 ^ sync_reg.s3));
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sync_reg <= '0;
		else
			sync_reg <= sync_next;
	end

	assign q_o = sync_reg.q;
endmodule : pes_sync
`default_nettype wire

/* File: core/pes_pat_mem.sv */
// internal one-dimensional pattern store with registered read
`timescale 1ns/10ps
`default_nettype none
module pes_pat_mem
	import pes_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	pes_mem_if.mem mif
);
	typedef struct packed {
		logic [MEM_DEPTH-1:0][PW-1:0] mem;
		logic [PW-1:0] rdata;
	} pes_mem_type;

	pes_mem_type mem_reg;
	pes_mem_type mem_next;

	always_comb
	begin
		mem_next = mem_reg;
		if (mif.we)
			mem_next.mem[mif.waddr] = mif.wdata;
		mem_next.rdata = mem_reg.mem[mif.raddr];
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mem_reg <= '0;
		else
			mem_reg <= mem_next;
	end

	assign mif.rdata = mem_reg.rdata;
endmodule : pes_pat_mem
`default_nettype wire

/* File: core/pes_top.sv */
// pattern exposure sequencer: apb registers, frame and pattern timing, triggers
// Function
// - 8-bit external mode accepts frames up to 120 Hz, 360 Hz patterns.
// - 8-bit external mode shows one, two or three patterns per frame.
// - all patterns in a frame share dark and exposure times; light only in exposure.
// - leftover frame time after last pattern stays dark until next frame.
// - 8-bit mode selects an illuminator per pattern during exposure.
// - frame trigger is a 20 us high pulse after delay from input sync.
// - pattern trigger high in exposure, delay from pattern start, shared per frame.
// - 1-bit mode takes frames up to 104.2 Hz, each input bit a pattern.
// - each 1-bit pattern runs at most 2500 Hz.
// - 1-bit mode uses one illuminator for every pattern of a frame.
// - internal mode shows one stored line replicated over the whole array.
// - on start command internal mode plays the loaded stored patterns.
// - internal frame sync comes from the stored pattern set period.
// - free running frame trigger delay counts from the internal frame sync.
// - trigger-in mode raises ready while a new advance can be accepted.
// - trigger-in frame trigger delay counts from the advance edge.
// - advance input only honoured in internal mode.
// - 8-bit mode packs one, two or three patterns into the 24-bit word.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pes_top
	import pes_pkg::*;
#(
	parameter logic [TW-1:0] PAT1_MIN_CYC_P = TW'(PAT1_MIN_CYC),
	parameter logic [TW-1:0] EXT8_MIN_FRAME_P = TW'(EXT8_MIN_FRAME_CYC),
	parameter logic [TW-1:0] EXT1_MIN_FRAME_P = TW'(EXT1_MIN_FRAME_CYC)
)(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pclk_i,
	input wire logic vsync_i,
	input wire logic data_enable_i,
	input wire logic [VW-1:0] pdata_i,
	input wire logic pattern_advance_i,
	output logic frame_trigger_o,
	output logic pattern_trigger_o,
	output logic trigger_accept_ready_o,
	output logic [ILL_W-1:0] illum_o,
	output logic [PW-1:0] pattern_data_o
);
	typedef struct packed {
		pes_mode_type mode;
		logic pattern_advance_in;
		logic run;
		logic [1:0] ppf;
		logic [5:0] cnt;
		logic [TW-1:0] pre;
		logic [TW-1:0] expo;
		logic [TW-1:0] post;
		logic [TW-1:0] ftd;
		logic [TW-1:0] ptd;
		logic [TW-1:0] set_period;
		logic [8:0] illum;
		logic [MEM_AW-1:0] maddr;
		logic mwe;
		logic [MEM_AW-1:0] mwaddr;
		logic [PW-1:0] mwdata;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic rate_err;
		pes_state_type st;
		logic [5:0] idx;
		logic [TW-1:0] tcnt;
		logic [TW-1:0] pat_el;
		logic [TW-1:0] frm_el;
		logic [TW-1:0] int_cnt;
		logic [TW-1:0] ftd_cnt;
		logic [TW-1:0] ptd_cnt;
		logic ftd_arm;
		logic [15:0] ftp_cnt;
		logic [VW-1:0] word;
		logic cap_pend;
		logic pclk_d;
		logic vs_d;
		logic adv_d;
		logic ftrig;
		logic ptrig;
		logic ready;
		logic [ILL_W-1:0] illum_o;
		logic [PW-1:0] pdata;
	} pes_top_state_type;

	pes_top_state_type r;
	pes_top_state_type n;
	pes_mem_if mif ();
	logic [VW+3:0] sy;
	logic pclk_s;
	logic vs_s;
	logic adv_s;
	logic de_s;
	logic acc;
	logic hit;
	logic [31:0] rdv;
	logic [5:0] np;
	logic ext_mode;
	logic int_free;
	logic int_trig;
	logic fs_ext;
	logic fs_free;
	logic fs;
	logic adv_ok;
	logic post_done;

	// ********************************
	// helpers
	// ********************************
	function automatic logic done(input logic [TW-1:0] c, input logic [TW-1:0] v);
		return (c + 24'h00_0001) >= v;
	endfunction : done

	function automatic logic [5:0] npat(input pes_mode_type m, input logic [1:0] ppf, input logic [5:0] cnt);
		if (m == MODE_EXT8)
			return (ppf == 2'd0) ? 6'd1 : {4'd0, ppf};
		if (m == MODE_EXT1)
			return (cnt == 6'd0) ? 6'd1 : ((cnt > 6'(EXT1_MAX_PAT)) ? 6'(EXT1_MAX_PAT) : cnt);
		return (cnt == 6'd0) ? 6'd1 : cnt;
	endfunction : npat

	function automatic logic [ILL_W-1:0] illum_pick(input pes_mode_type m, input logic [8:0] il, input logic [5:0] i);
		if (m != MODE_EXT8)
			return il[2:0];
		unique case (i[1:0])
			2'd1: return il[5:3];
			2'd2: return il[8:6];
			default: return il[2:0];
		endcase
	endfunction : illum_pick

	// ********************************
	// input synchronisers and pattern memory
	// ********************************
	pes_sync #(
		.W(VW + 4)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.d_i({data_enable_i, pattern_advance_i, pclk_i, vsync_i, pdata_i}),
		.q_o(sy)
	);

	pes_pat_mem u_mem (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.mif(mif.mem)
	);

	assign de_s = sy[VW+3];
	assign adv_s = sy[VW+2];
	assign pclk_s = sy[VW+1];
	assign vs_s = sy[VW];
	assign mif.we = r.mwe;
	assign mif.waddr = r.mwaddr;
	assign mif.wdata = r.mwdata;
	assign mif.raddr = r.idx;

	// ********************************
	// register decode
	// ********************************
	always_comb
	begin
		hit = 1'b1;
		rdv = 32'h0000_0000;
		case (paddr_i)
			REG_CTRL:
			begin
				rdv[CTRL_MODE_LSB +: 2] = r.mode;
				rdv[CTRL_TRIGIN_BIT] = r.pattern_advance_in;
				rdv[CTRL_RUN_BIT] = r.run;
				rdv[CTRL_PPF_LSB +: 2] = r.ppf;
				rdv[CTRL_CNT_LSB +: 6] = r.cnt;
			end
			REG_PRE_DARK: rdv[TW-1:0] = r.pre;
			REG_EXPOSURE: rdv[TW-1:0] = r.expo;
			REG_POST_DARK: rdv[TW-1:0] = r.post;
			REG_FTRIG_DLY: rdv[TW-1:0] = r.ftd;
			REG_PTRIG_DLY: rdv[TW-1:0] = r.ptd;
			REG_ILLUM: rdv[8:0] = r.illum;
			REG_SET_PERIOD: rdv[TW-1:0] = r.set_period;
			REG_MEM_ADDR: rdv[MEM_AW-1:0] = r.maddr;
			REG_MEM_DATA: rdv = 32'h0000_0000;
			REG_STATUS:
			begin
				rdv[STAT_READY_BIT] = r.ready;
				rdv[STAT_RATE_BIT] = r.rate_err;
				rdv[STAT_ST_LSB +: 3] = r.st;
				rdv[STAT_IDX_LSB +: 6] = r.idx;
			end
			default: hit = 1'b0;
		endcase
	end

	// ********************************
	// next state
	// ********************************
	always_comb
	begin
		n = r;
		acc = psel_i & penable_i;
		n.mwe = 1'b0;
		n.pready = acc & ~r.pready;
		n.pslverr = 1'b0;
		if (acc & ~r.pready)
		begin
			n.pslverr = ~hit;
			n.prdata = hit ? rdv : 32'h0000_0000;
		end
		if (acc & r.pready & pwrite_i)
		begin
			case (paddr_i)
				REG_CTRL:
				begin
					n.mode = pes_mode_type'(pwdata_i[CTRL_MODE_LSB +: 2]);
					n.pattern_advance_in = pwdata_i[CTRL_TRIGIN_BIT];
					n.run = pwdata_i[CTRL_RUN_BIT];
					n.ppf = pwdata_i[CTRL_PPF_LSB +: 2];
					n.cnt = pwdata_i[CTRL_CNT_LSB +: 6];
				end
				REG_PRE_DARK: n.pre = pwdata_i[TW-1:0];
				REG_EXPOSURE: n.expo = pwdata_i[TW-1:0];
				REG_POST_DARK: n.post = pwdata_i[TW-1:0];
				REG_FTRIG_DLY: n.ftd = pwdata_i[TW-1:0];
				REG_PTRIG_DLY: n.ptd = pwdata_i[TW-1:0];
				REG_ILLUM: n.illum = pwdata_i[8:0];
				REG_SET_PERIOD: n.set_period = pwdata_i[TW-1:0];
				REG_MEM_ADDR: n.maddr = pwdata_i[MEM_AW-1:0];
				REG_MEM_DATA:
				begin
					n.mwe = 1'b1;
					n.mwaddr = r.maddr;
					n.mwdata = pwdata_i[PW-1:0];
					n.maddr = r.maddr + 6'd1;
				end
				REG_STATUS:
				begin
					if (pwdata_i[STAT_RATE_BIT])
						n.rate_err = 1'b0;
				end
				default: ;
			endcase
		end

		// frame sources
		n.pclk_d = pclk_s;
		n.vs_d = vs_s;
		n.adv_d = adv_s;
		np = npat(r.mode, r.ppf, r.cnt);
		ext_mode = (r.mode == MODE_EXT8) | (r.mode == MODE_EXT1);
		int_free = (r.mode == MODE_INT) & r.run & ~r.pattern_advance_in;
		int_trig = (r.mode == MODE_INT) & r.run & r.pattern_advance_in;
		fs_ext = ext_mode & vs_s & ~r.vs_d;
		fs_free = int_free & done(r.int_cnt, r.set_period);
		n.int_cnt = int_free ? (fs_free ? TIME_RST : r.int_cnt + 24'h00_0001) : TIME_RST;
		adv_ok = int_trig & adv_s & ~r.adv_d & r.ready;
		fs = fs_ext | fs_free;

		// frame rate watch
		n.frm_el = (r.frm_el != '1) ? r.frm_el + 24'h00_0001 : r.frm_el;
		if (fs_ext)
		begin
			n.frm_el = TIME_RST;
			if (r.st != S_IDLE && (r.st != S_FILL ||
				r.frm_el < ((r.mode == MODE_EXT8) ? EXT8_MIN_FRAME_P : EXT1_MIN_FRAME_P)))
				n.rate_err = 1'b1;
			n.cap_pend = 1'b1;
		end
		if (r.cap_pend & pclk_s & ~r.pclk_d & de_s)
		begin
			n.word = sy[VW-1:0];
			n.cap_pend = 1'b0;
		end

		// pattern sequence
		n.tcnt = r.tcnt + 24'h00_0001;
		n.pat_el = r.pat_el + 24'h00_0001;
		n.ptd_cnt = (r.ptd_cnt != TIME_RST) ? r.ptd_cnt - 24'h00_0001 : r.ptd_cnt;
		post_done = done(r.tcnt, r.post) && (r.mode != MODE_EXT1 || done(r.pat_el, PAT1_MIN_CYC_P));
		unique case (r.st)
			S_IDLE:
			begin
				if (int_trig)
				begin
					n.st = S_WAIT;
					n.idx = 6'd0;
				end
			end
			S_PRE:
			begin
				if (done(r.tcnt, r.pre))
				begin
					n.st = S_EXP;
					n.tcnt = TIME_RST;
				end
			end
			S_EXP:
			begin
				if (done(r.tcnt, r.expo))
				begin
					n.st = S_POST;
					n.tcnt = TIME_RST;
				end
			end
			S_POST:
			begin
				if (post_done)
				begin
					if (int_trig)
					begin
						n.st = S_WAIT;
						n.idx = (r.idx + 6'd1 >= np) ? 6'd0 : r.idx + 6'd1;
					end
					else if (r.idx + 6'd1 < np)
					begin
						n.st = S_PRE;
						n.idx = r.idx + 6'd1;
						n.tcnt = TIME_RST;
						n.pat_el = TIME_RST;
						n.ptd_cnt = r.ptd;
					end
					else
						n.st = S_FILL;
				end
			end
			S_FILL: ;
			S_WAIT:
			begin
				if (adv_ok)
				begin
					n.st = S_PRE;
					n.tcnt = TIME_RST;
					n.pat_el = TIME_RST;
					n.ptd_cnt = r.ptd;
				end
			end
		endcase
		if (fs)
		begin
			n.st = S_PRE;
			n.idx = 6'd0;
			n.tcnt = TIME_RST;
			n.pat_el = TIME_RST;
			n.ptd_cnt = r.ptd;
		end
		if (!(ext_mode | int_free | int_trig) || (r.st == S_WAIT && !int_trig))
		begin
			n.st = S_IDLE;
			n.idx = 6'd0;
		end
		n.ready = (n.st == S_WAIT);

		// frame trigger delay and pulse
		if (r.ftp_cnt != 16'h0000)
			n.ftp_cnt = r.ftp_cnt - 16'h0001;
		if (r.ftd_arm)
		begin
			if (r.ftd_cnt == TIME_RST)
			begin
				n.ftd_arm = 1'b0;
				n.ftp_cnt = 16'(FTRIG_CYC);
			end
			else
				n.ftd_cnt = r.ftd_cnt - 24'h00_0001;
		end
		if (fs | (adv_ok & (r.idx == 6'd0)))
		begin
			n.ftd_arm = 1'b1;
			n.ftd_cnt = r.ftd;
		end
		n.ftrig = (n.ftp_cnt != 16'h0000);

		// pattern trigger, light and data
		n.ptrig = (n.st == S_EXP) && (n.ptd_cnt == TIME_RST);
		n.illum_o = (n.st == S_EXP) ? illum_pick(r.mode, r.illum, n.idx) : 3'd0;
		unique case (r.mode)
			MODE_EXT8: n.pdata = r.word[n.idx[1:0] * 8 +: 8];
			MODE_EXT1: n.pdata = {PW{r.word[n.idx[4:0]]}};
			MODE_INT: n.pdata = mif.rdata;
			MODE_OFF: n.pdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			r <= '0;
		else
			r <= n;
	end

	assign prdata_o = r.prdata;
	assign pready_o = r.pready;
	assign pslverr_o = r.pslverr;
	assign frame_trigger_o = r.ftrig;
	assign pattern_trigger_o = r.ptrig;
	assign trigger_accept_ready_o = r.ready;
	assign illum_o = r.illum_o;
	assign pattern_data_o = r.pdata;
endmodule : pes_top
`default_nettype wire

/* File: tb/pes_video_src.sv */
// video source and camera trigger partner model
`timescale 1ns/10ps
`default_nettype none
module pes_video_src
	import pes_pkg::*;
(
	output logic pclk_o,
	output logic vsync_o,
	output logic de_o,
	output logic [VW-1:0] pdata_o,
	output logic advance_o
);
	initial
	begin
		pclk_o = 1'b0;
		vsync_o = 1'b0;
		de_o = 1'b0;
		pdata_o = 24'h5A_5A5A;
		advance_o = 1'b0;
		forever #80 pclk_o = ~pclk_o;
	end
	// ****
	// sync edge, one valid word, then released lines
	// ****
	task automatic frame(input logic [VW-1:0] w);
		@(posedge pclk_o);
		vsync_o <= 1'b1;
		@(posedge pclk_o);
		de_o <= 1'b1;
		pdata_o <= w;
		@(posedge pclk_o);
		vsync_o <= 1'b0;
		@(posedge pclk_o);
		de_o <= 1'b0;
		pdata_o <= ~w;
	endtask : frame
	task automatic adv();
		@(posedge pclk_o);
		advance_o <= 1'b1;
		repeat (2) @(posedge pclk_o);
		advance_o <= 1'b0;
	endtask : adv
endmodule : pes_video_src
`default_nettype wire

/* File: tb/pes_top_sva.sv */
// port checker for the pattern exposure sequencer
`timescale 1ns/10ps
`default_nettype none
module pes_top_sva
	import pes_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pattern_advance_i,
	input wire logic frame_trigger_o,
	input wire logic pattern_trigger_o,
	input wire logic trigger_accept_ready_o,
	input wire logic [ILL_W-1:0] illum_o,
	input wire logic [PW-1:0] pattern_data_o
);
	logic [TW-1:0] pre_reg, exp_reg, lit_cnt, dark_cnt, pre_m, exp_m;
	logic [8:0] ill_reg;
	logic [3:0] ctrl_reg;
	logic [10:0] ftr_cnt;
	logic wr_ok, lit, ill_ok;
	assign wr_ok = psel_i && penable_i && pwrite_i && pready_o;
	assign lit = |illum_o;
	assign ill_ok = (ill_reg[2:0] != 3'h0) && (ill_reg[5:3] != 3'h0) && (ill_reg[8:6] != 3'h0);
	assign pre_m = (pre_reg == 24'h0) ? 24'h1 : pre_reg;
	assign exp_m = (exp_reg == 24'h0) ? 24'h1 : exp_reg;
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pre_reg <= '0;
			exp_reg <= '0;
			ill_reg <= '0;
			ctrl_reg <= '0;
			ftr_cnt <= '0;
			lit_cnt <= '0;
			dark_cnt <= '0;
		end
		else
		begin
			if (wr_ok && paddr_i == REG_PRE_DARK)
				pre_reg <= pwdata_i[TW-1:0];
			if (wr_ok && paddr_i == REG_EXPOSURE)
				exp_reg <= pwdata_i[TW-1:0];
			if (wr_ok && paddr_i == REG_ILLUM)
				ill_reg <= pwdata_i[8:0];
			if (wr_ok && paddr_i == REG_CTRL)
				ctrl_reg <= pwdata_i[3:0];
			ftr_cnt <= frame_trigger_o ? ftr_cnt + 11'h1 : 11'h0;
			lit_cnt <= lit ? lit_cnt + 24'h1 : 24'h0;
			dark_cnt <= lit ? 24'h0 : dark_cnt + 24'h1;
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	chk_ftrig_width: assert property ($fell(frame_trigger_o) |-> ftr_cnt >= 11'(FTRIG_CYC))
		else $error("frame trigger pulse too short");
	chk_exp_length: assert property ($fell(lit) |-> lit_cnt == exp_m)
		else $error("exposure length wrong");
	chk_pre_dark: assert property ($rose(lit) |-> dark_cnt >= pre_m)
		else $error("pre dark interval too short");
	chk_ptrig_lit: assert property (pattern_trigger_o && ill_ok |-> lit)
		else $error("pattern trigger outside exposure");
	chk_exp_stable: assert property (lit && $past(lit) |-> $stable(pattern_data_o) && $stable(illum_o))
		else $error("pattern changed during exposure");
	chk_ready_dark: assert property (trigger_accept_ready_o |-> !lit && !pattern_trigger_o)
		else $error("ready while pattern active");
	chk_ready_drop: assert property (trigger_accept_ready_o && $rose(pattern_advance_i) |-> ##[1:12] !trigger_accept_ready_o)
		else $error("ready did not drop on advance");
	chk_ready_mode: assert property ($rose(trigger_accept_ready_o) |-> ctrl_reg == 4'hF)
		else $error("ready outside trigger-in mode");
endmodule : pes_top_sva
bind pes_top pes_top_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pattern_advance_i(pattern_advance_i), .frame_trigger_o(frame_trigger_o), .pattern_trigger_o(pattern_trigger_o),
	.trigger_accept_ready_o(trigger_accept_ready_o), .illum_o(illum_o), .pattern_data_o(pattern_data_o));
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the pattern exposure sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import pes_pkg::*;
;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, pclk, vsync, de, adv, ftr, ptr, rdy, er;
	logic lit_q = 1'b0, ftr_q = 1'b0;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [VW-1:0] pdata;
	logic [ILL_W-1:0] illum;
	logic [PW-1:0] pdat;
	logic [ILL_W-1:0] rec_ill [64];
	logic [PW-1:0] rec_dat [64];
	int rec_t [64];
	int n_fail = 0, n_checks = 0, n_exp = 0, n_ftr = 0, n_ptr = 0, cyc = 0, b, f, pt;
	localparam logic [VW-1:0] W8 = 24'h3C_96A5;
	localparam logic [VW-1:0] W1 = 24'h96_3C5A;
	localparam logic [APB_AW-1:0] CFG_A [7] = '{REG_PRE_DARK, REG_EXPOSURE, REG_POST_DARK, REG_FTRIG_DLY,
		REG_PTRIG_DLY, REG_ILLUM, REG_SET_PERIOD};
	localparam logic [31:0] CFG_D [7] = '{32'h3C, 32'h3, 32'h2, 32'h5, 32'h3D, 32'h111, 32'h4B0};
	localparam logic [PW-1:0] MEMW [3] = '{8'h3C, 8'hC3, 8'h7E};
	pes_top #(.PAT1_MIN_CYC_P(24'h50), .EXT8_MIN_FRAME_P(24'hC8), .EXT1_MIN_FRAME_P(24'hC8)) u_dut (
		.mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pclk_i(pclk),
		.vsync_i(vsync), .data_enable_i(de), .pdata_i(pdata), .pattern_advance_i(adv), .frame_trigger_o(ftr),
		.pattern_trigger_o(ptr), .trigger_accept_ready_o(rdy), .illum_o(illum), .pattern_data_o(pdat));
	pes_video_src u_src (.pclk_o(pclk), .vsync_o(vsync), .de_o(de), .pdata_o(pdata), .advance_o(adv));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ****
	// exposure and frame trigger recorder
	// ****
	always @(posedge mclk)
	begin
		cyc++;
		if (ftr && !ftr_q)
			n_ftr++;
		if (ptr)
			n_ptr++;
		if ((|illum) && !lit_q)
		begin
			rec_ill[n_exp] = illum;
			rec_dat[n_exp] = pdat;
			rec_t[n_exp] = cyc;
			n_exp++;
		end
		lit_q = |illum;
		ftr_q = ftr;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wrdy(input logic v);
		int k;
		k = 0;
		while (rdy !== v && k < 3000)
		begin
			@(negedge mclk);
			k++;
		end
		cmp(rdy, v);
	endtask : wrdy
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		summarize();
	end
	// ****
	// main sequence
	// ****
	initial
	begin
		{rst_b, psel, penable, pwrite} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		cmp({ftr, ptr, rdy, illum, pdat}, 0);
		foreach (CFG_A[i])
			apb(1'b1, CFG_A[i], CFG_D[i]);
		apb(1'b0, REG_PRE_DARK, 0);
		cmp(rd, 32'h3C);
		apb(1'b0, 8'hFC, 0);
		cmp({31'h0000_0000, er}, 32'h0000_0001);
		cmp(rd, 32'h0000_0000);
		for (int p = 1; p <= 3; p++)
		begin
			b = n_exp;
			f = n_ftr;
			pt = n_ptr;
			apb(1'b1, REG_CTRL, 32'(1 + (p << 4)));
			u_src.frame(W8);
			repeat (1100) @(posedge mclk);
			cmp(n_exp - b, p);
			cmp(n_ptr - pt, 2 * p);
			cmp(n_ftr - f, 1);
			for (int i = 0; i < p; i++)
			begin
				cmp(rec_ill[b + i], (9'h111 >> (3 * i)) & 9'h7);
				cmp(rec_dat[b + i], W8[8 * i +: 8]);
			end
			apb(1'b0, REG_STATUS, 0);
			cmp(rd[6:0], 7'h40);
		end
		b = n_exp;
		u_src.adv();
		repeat (60) @(posedge mclk);
		cmp({n_exp - b, rdy}, 0);
		u_src.frame(W8);
		u_src.frame(W8);
		repeat (1100) @(posedge mclk);
		apb(1'b0, REG_STATUS, 0);
		cmp(rd[1], 1'b1);
		apb(1'b1, REG_STATUS, 32'h2);
		apb(1'b0, REG_STATUS, 0);
		cmp(rd[1], 1'b0);
		b = n_exp;
		apb(1'b1, REG_CTRL, 32'h1E02);
		u_src.frame(W1);
		repeat (2100) @(posedge mclk);
		cmp(n_exp - b, 24);
		for (int i = 0; i < 24; i++)
		begin
			cmp(rec_ill[b + i], 1);
			cmp(rec_dat[b + i], {8{W1[i]}});
			if (i > 0)
				cmp(rec_t[b + i] - rec_t[b + i - 1], 80);
		end
		apb(1'b1, REG_MEM_ADDR, 0);
		foreach (MEMW[i])
			apb(1'b1, REG_MEM_DATA, MEMW[i]);
		b = n_exp;
		f = n_ftr;
		apb(1'b1, REG_CTRL, 32'h30B);
		repeat (2700) @(posedge mclk);
		cmp(n_exp - b >= 6, 1);
		cmp(rec_t[b + 3] - rec_t[b], 1200);
		cmp(n_ftr - f >= 2, 1);
		for (int i = 0; i < 4; i++)
			cmp(rec_dat[b + i], MEMW[i % 3]);
		apb(1'b1, REG_CTRL, 0);
		while (ftr !== 1'b0)
			@(posedge mclk);
		apb(1'b1, REG_CTRL, 32'h20F);
		wrdy(1'b1);
		b = n_exp;
		f = n_ftr;
		for (int i = 0; i < 2; i++)
		begin
			u_src.adv();
			wrdy(1'b1);
			cmp(n_exp - b, i + 1);
			cmp(n_ftr - f, 1);
			cmp(rec_dat[b + i], MEMW[i]);
			repeat (1100) @(posedge mclk);
		end
		summarize();
	end
endmodule : tb_top
`default_nettype wire
